// ---- common/memory_io_timer_array_defs.vh ----
`ifndef MEMORY_IO_TIMER_ARRAY_DEFS_VH
`define MEMORY_IO_TIMER_ARRAY_DEFS_VH
// ==========================================
// Internal element decode (address bits)
// ==========================================
`define MIT_SEL_TIMER_BIT 2
`define MIT_IRQ_EN_BIT 3
`define MIT_REG_PORT_A 2'h0
`define MIT_REG_DIR_A 2'h1
`define MIT_REG_PORT_B 2'h2
`define MIT_REG_DIR_B 2'h3
// Timer read: address bit 0 picks count or flag
`define MIT_TMR_RD_FLAG_BIT 0
// ==========================================
// Prescale codes and terminal masks
// ==========================================
`define MIT_DIV_1 2'h0
`define MIT_DIV_8 2'h1
`define MIT_DIV_64 2'h2
`define MIT_DIV_1024 2'h3
`define MIT_MASK_1 10'h000
`define MIT_MASK_8 10'h007
`define MIT_MASK_64 10'h03f
`define MIT_MASK_1024 10'h3ff
// ==========================================
// Reset values, count zero and wrap load
// ==========================================
`define MIT_RST_DIR 8'h00
`define MIT_RST_LATCH 8'h00
`define MIT_RST_COUNT 8'h00
`define MIT_RST_PRESC 10'h000
`define MIT_RST_DATA 8'h00
`define MIT_PIN_IDLE 8'hff
`define MIT_COUNT_ZERO 8'h00
`define MIT_COUNT_WRAP 8'hff
`endif

// ---- rtl/memory_io_timer_array.v ----
// Behaviour
// - Reset clears directions, latches, interrupt enable
// - Data drivers off except during reads
// - Direction input high reads, low writes
// - Interrupt pin idles high, low pending
// - Direction bit one drives latch out
// - Input pins held high, read one
// - Port read: pins for inputs, latch outputs
// - Latch changes only on host writes
// - Bits five, six build-time chip selects
// - ROM 1024 bytes, ten address bits
// - RAM 64 bytes, six address bits
// - Eight-bit count, prescale 1/8/64/1024
// - Timer write loads count and prescale
// - Address bit three sets interrupt enable
// - Read before flag gives intervals left
// - Zero then next event: flag, wrap, fast
// - After flag read gives elapsed periods
// - Write or later count read clears flag
// - Flag read on bit seven, rest zero
`include "memory_io_timer_array_defs.vh"
`default_nettype none

module memory_io_timer_array #(
   parameter CS1_IS_SELECT = 1,
   parameter CS2_IS_SELECT = 1,
   parameter CS1_ACTIVE = 1'b0,
   parameter CS2_ACTIVE = 1'b0,
   parameter [7:0] ROM_SEED = 8'h5a
) (
   input wire core_clk,
   input wire rstn,
   input wire access_strobe,
   input wire read_not_write,
   input wire [9:0] host_address_pins,
   input wire rom_region_select,
   input wire ram_select,
   input wire io_timer_select,
   input wire [7:0] host_data_in,
   output reg [7:0] host_data_out,
   output reg [7:0] host_data_oe_n,
   input wire [7:0] port_a_in,
   output reg [7:0] port_a_out,
   output reg [7:0] port_a_oe_n,
   input wire [7:0] port_b_in,
   output reg [7:0] port_b_out,
   output reg [7:0] port_b_oe_n
);

   // ==========================================
   // Functions
   // ==========================================
   // Mask ROM contents; the pattern stands in for a customer mask
   function [7:0] rom_byte;
      input [9:0] addr;
      begin
         rom_byte = addr[7:0] ^ {6'h00, addr[9:8]} ^ ROM_SEED;
      end
   endfunction

   // Prescaler terminal mask for a divide choice
   function [9:0] div_mask;
      input [1:0] sel;
      begin
         case (sel)
            `MIT_DIV_1: div_mask = `MIT_MASK_1;
            `MIT_DIV_8: div_mask = `MIT_MASK_8;
            `MIT_DIV_64: div_mask = `MIT_MASK_64;
            default: div_mask = `MIT_MASK_1024;
         endcase
      end
   endfunction

   // Port read: pins where input, latch where output
   function [7:0] port_read;
      input [7:0] pins;
      input [7:0] latch;
      input [7:0] dir;
      begin
         port_read = (pins & ~dir) | (latch & dir);
      end
   endfunction

   // ==========================================
   // State
   // ==========================================
   reg [7:0] dir_a_r;
   reg [7:0] dir_b_r;
   reg [7:0] latch_a_r;
   reg [7:0] latch_b_r;
   reg [7:0] count_r;
   reg [9:0] presc_r;
   reg [1:0] div_sel_r;
   reg flag_r;
   reg irq_en_r;
   reg fast_r;
   reg [7:0] ram [0:63];
   reg [7:0] pa_s1_r;
   reg [7:0] pa_s2_r;
   reg [7:0] pa_s3_r;
   reg [7:0] pa_r;
   reg [7:0] pb_s1_r;
   reg [7:0] pb_s2_r;
   reg [7:0] pb_s3_r;
   reg [7:0] pb_r;

   // ==========================================
   // Pin synchronisers
   // ==========================================
   // Three stages; value accepted once stages two and three agree
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pa_s1_r <= `MIT_PIN_IDLE;
         pa_s2_r <= `MIT_PIN_IDLE;
         pa_s3_r <= `MIT_PIN_IDLE;
         pa_r <= `MIT_PIN_IDLE;
         pb_s1_r <= `MIT_PIN_IDLE;
         pb_s2_r <= `MIT_PIN_IDLE;
         pb_s3_r <= `MIT_PIN_IDLE;
         pb_r <= `MIT_PIN_IDLE;
      end else begin
         pa_s1_r <= port_a_in;
         pa_s2_r <= pa_s1_r;
         pa_s3_r <= pa_s2_r;
         pa_r <= (pa_s2_r & pa_s3_r) | (pa_r & (pa_s2_r ^ pa_s3_r));
         pb_s1_r <= port_b_in;
         pb_s2_r <= pb_s1_r;
         pb_s3_r <= pb_s2_r;
         pb_r <= (pb_s2_r & pb_s3_r) | (pb_r & (pb_s2_r ^ pb_s3_r));
      end
   end

   // ==========================================
   // Address decode
   // ==========================================
   wire cs1_ok;
   wire cs2_ok;
   wire chip_sel;
   wire rom_acc;
   wire ram_acc;
   wire io_acc;
   wire tmr_acc;
   wire reg_acc;
   wire is_read;
   wire is_write;
   wire [1:0] reg_sel;

   // Chip selects only when built as such; a port build ignores the pin
   assign cs1_ok = (CS1_IS_SELECT == 0) || (pb_r[5] == CS1_ACTIVE);
   assign cs2_ok = (CS2_IS_SELECT == 0) || (pb_r[6] == CS2_ACTIVE);
   assign chip_sel = access_strobe & cs1_ok & cs2_ok;
   assign is_read = read_not_write;
   assign is_write = ~read_not_write;
   assign rom_acc = chip_sel & rom_region_select;
   assign ram_acc = chip_sel & ~rom_region_select & ram_select;
   assign io_acc = chip_sel & ~rom_region_select & ~ram_select & io_timer_select;
   assign tmr_acc = io_acc & host_address_pins[`MIT_SEL_TIMER_BIT];
   assign reg_acc = io_acc & ~host_address_pins[`MIT_SEL_TIMER_BIT];
   assign reg_sel = host_address_pins[1:0];

   // ==========================================
   // Port registers
   // ==========================================
   // Reads never touch the latches; only a write can change them
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dir_a_r <= `MIT_RST_DIR;
         dir_b_r <= `MIT_RST_DIR;
         latch_a_r <= `MIT_RST_LATCH;
         latch_b_r <= `MIT_RST_LATCH;
      end else if (reg_acc && is_write) begin
         case (reg_sel)
            `MIT_REG_PORT_A: latch_a_r <= host_data_in;
            `MIT_REG_DIR_A: dir_a_r <= host_data_in;
            `MIT_REG_PORT_B: latch_b_r <= host_data_in;
            default: dir_b_r <= host_data_in;
         endcase
      end
   end

   // RAM write; no reset so it maps to plain storage
   always @(posedge core_clk) begin
      if (ram_acc && is_write) begin
         ram[host_address_pins[5:0]] <= host_data_in;
      end
   end

   // ==========================================
   // Interval timer
   // ==========================================
   wire tick;
   wire set_flag;
   wire tmr_wr;
   wire tmr_rd;
   wire [9:0] presc_mask;

   // Once the count has wrapped the prescale is bypassed until a write
   assign presc_mask = div_mask(div_sel_r);
   assign tick = fast_r | ((presc_r & presc_mask) == presc_mask);
   assign set_flag = tick & ~fast_r & (count_r == `MIT_COUNT_ZERO);
   assign tmr_wr = tmr_acc & is_write;
   assign tmr_rd = tmr_acc & is_read;

   // Counter, prescaler and divide choice
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= `MIT_RST_COUNT;
         presc_r <= `MIT_RST_PRESC;
         div_sel_r <= `MIT_DIV_1;
      end else if (tmr_wr) begin
         count_r <= host_data_in;
         div_sel_r <= host_address_pins[1:0];
         presc_r <= `MIT_RST_PRESC;
      end else begin
         presc_r <= presc_r + 10'h001;
         if (set_flag) begin
            count_r <= `MIT_COUNT_WRAP;
         end else if (tick) begin
            count_r <= count_r - 8'h01;
         end
      end
   end

   // Flag and enable; setting beats a same-cycle read clear
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flag_r <= 1'b0;
         irq_en_r <= 1'b0;
      end else begin
         if (tmr_acc) begin
            irq_en_r <= host_address_pins[`MIT_IRQ_EN_BIT];
         end
         if (tmr_wr) begin
            flag_r <= 1'b0;
         end else if (set_flag) begin
            flag_r <= 1'b1;
         end else if (tmr_rd && !host_address_pins[`MIT_TMR_RD_FLAG_BIT]) begin
            flag_r <= 1'b0;
         end
      end
   end

   // Kept apart from the flag so a clearing read keeps the fast rate
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fast_r <= 1'b0;
      end else if (tmr_wr) begin
         fast_r <= 1'b0;
      end else if (set_flag) begin
         fast_r <= 1'b1;
      end
   end

   // ==========================================
   // Read data path
   // ==========================================
   reg [7:0] rd_nxt;
   reg rd_en_nxt;

   // Select the byte a read returns
   always @* begin
      rd_nxt = `MIT_RST_DATA;
      rd_en_nxt = chip_sel & is_read & (rom_acc | ram_acc | io_acc);
      if (rom_acc) begin
         rd_nxt = rom_byte(host_address_pins);
      end else if (ram_acc) begin
         rd_nxt = ram[host_address_pins[5:0]];
      end else if (tmr_acc) begin
         if (host_address_pins[`MIT_TMR_RD_FLAG_BIT]) begin
            rd_nxt = {flag_r, 7'h00};
         end else begin
            rd_nxt = count_r;
         end
      end else if (reg_acc) begin
         case (reg_sel)
            `MIT_REG_PORT_A: rd_nxt = port_read(pa_r, latch_a_r, dir_a_r);
            `MIT_REG_DIR_A: rd_nxt = dir_a_r;
            `MIT_REG_PORT_B: rd_nxt = port_read(pb_r, latch_b_r, dir_b_r);
            default: rd_nxt = dir_b_r;
         endcase
      end
   end

   // Drivers enabled only for the cycle of a read answer
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         host_data_out <= `MIT_RST_DATA;
         host_data_oe_n <= 8'hff;
      end else begin
         host_data_out <= rd_nxt;
         host_data_oe_n <= {8{~rd_en_nxt}};
      end
   end

   // ==========================================
   // Port pin drivers
   // ==========================================
   reg [7:0] pa_out_nxt;
   reg [7:0] pa_oe_nxt;
   reg [7:0] pb_out_nxt;
   reg [7:0] pb_oe_nxt;

   // Inputs float at the high level; outputs drive the latch
   always @* begin
      pa_out_nxt = latch_a_r | ~dir_a_r;
      pa_oe_nxt = ~dir_a_r;
      pb_out_nxt = latch_b_r | ~dir_b_r;
      pb_oe_nxt = ~dir_b_r;
      if (CS1_IS_SELECT != 0) begin
         pb_oe_nxt[5] = 1'b1;
         pb_out_nxt[5] = 1'b1;
      end
      if (CS2_IS_SELECT != 0) begin
         pb_oe_nxt[6] = 1'b1;
         pb_out_nxt[6] = 1'b1;
      end
      // Pending interrupt pulls bit seven low, overriding the port
      if (irq_en_r && flag_r) begin
         pb_out_nxt[7] = 1'b0;
         pb_oe_nxt[7] = 1'b0;
      end
   end

   // Registered pin drive; costs a cycle but keeps outputs clean
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         port_a_out <= `MIT_PIN_IDLE;
         port_a_oe_n <= 8'hff;
         port_b_out <= `MIT_PIN_IDLE;
         port_b_oe_n <= 8'hff;
      end else begin
         port_a_out <= pa_out_nxt;
         port_a_oe_n <= pa_oe_nxt;
         port_b_out <= pb_out_nxt;
         port_b_oe_n <= pb_oe_nxt;
      end
   end

endmodule // memory_io_timer_array

`default_nettype wire

// ---- verif/mit_checker_properties.sv ----
`default_nettype none
// ==========================================
// Port-level checker for the memory/io/timer block
// ==========================================
module mit_checker (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic access_strobe,
   input wire logic read_not_write,
   input wire logic [7:0] host_data_oe_n,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_oe_n,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_b_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr;
   // Host write strobe, the only legal cause of a latch change
   assign wr = access_strobe & ~read_not_write;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   chk_reset_outs_off: assert property (disable iff (1'b0) !rstn |->
      host_data_oe_n == 8'hff && port_a_oe_n == 8'hff && port_b_oe_n == 8'hff)
      else $error("outputs not released in reset");
   chk_oe_all_equal: assert property (host_data_oe_n == 8'h00 || host_data_oe_n == 8'hff)
      else $error("data enables split");
   chk_oe_read_only: assert property (host_data_oe_n == 8'h00 |->
      $past(access_strobe) && $past(read_not_write))
      else $error("data driven without read");
   chk_oe_idle_off: assert property (!(access_strobe && read_not_write) |=>
      host_data_oe_n == 8'hff)
      else $error("data driven after non-read");
   chk_a_input_high: assert property ((port_a_out | ~port_a_oe_n) == 8'hff)
      else $error("port a input bit not high");
   chk_b_input_high: assert property ((port_b_out | ~port_b_oe_n) == 8'hff)
      else $error("port b input bit not high");
   chk_select_bits_quiet: assert property (port_b_oe_n[6:5] == 2'b11)
      else $error("select pin driven");
   chk_a_write_only: assert property ($changed(port_a_out) || $changed(port_a_oe_n) |->
      $past(wr, 1) || $past(wr, 2))
      else $error("port a changed without write");
   cover property (access_strobe && read_not_write ##1 host_data_oe_n == 8'h00);
   cover property (!port_b_oe_n[7] && !port_b_out[7]);
   cover property (port_a_oe_n != 8'hff);
endmodule // mit_checker

bind memory_io_timer_array mit_checker u_mit_checker (.core_clk(core_clk), .rstn(rstn),
   .access_strobe(access_strobe), .read_not_write(read_not_write),
   .host_data_oe_n(host_data_oe_n), .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n),
   .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n));
`default_nettype wire

// ---- verif/pin_partner.sv ----
`default_nettype none
// ==========================================
// Peripheral side of both ports
// ==========================================
module pin_partner (
   input wire logic [7:0] a_out,
   input wire logic [7:0] a_oe_n,
   input wire logic [7:0] b_out,
   input wire logic [7:0] b_oe_n,
   input wire logic [7:0] a_en,
   input wire logic [7:0] a_val,
   input wire logic [7:0] b_en,
   input wire logic [7:0] b_val,
   output logic [7:0] a_pin,
   output logic [7:0] b_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Device drive first, then peripheral, else pull-up; never a stale value
   assign a_pin = (~a_oe_n & a_out) | (a_oe_n & a_en & a_val) | (a_oe_n & ~a_en);
   assign b_pin = (~b_oe_n & b_out) | (b_oe_n & b_en & b_val) | (b_oe_n & ~b_en);
endmodule // pin_partner
`default_nettype wire

// ---- verif/testbench.sv ----
`default_nettype none
// ==========================================
// Host-side bench
// ==========================================
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rstn, stb, rnw, rom_s, ram_s, io_s;
   logic [9:0] adr;
   logic [7:0] din, dout, doe_n, pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n;
   logic [7:0] ea_en, ea_v, eb_en, eb_v, rv, ov, t0;
   int err_count, cmp_count, k, n;
   memory_io_timer_array u_memory_io_timer_array (.core_clk(core_clk), .rstn(rstn),
      .access_strobe(stb), .read_not_write(rnw), .host_address_pins(adr),
      .rom_region_select(rom_s), .ram_select(ram_s), .io_timer_select(io_s),
      .host_data_in(din), .host_data_out(dout), .host_data_oe_n(doe_n),
      .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe_n(pa_oe_n),
      .port_b_in(pb_in), .port_b_out(pb_out), .port_b_oe_n(pb_oe_n));
   pin_partner u_pin_partner (.a_out(pa_out), .a_oe_n(pa_oe_n), .b_out(pb_out),
      .b_oe_n(pb_oe_n), .a_en(ea_en), .a_val(ea_v), .b_en(eb_en), .b_val(eb_v),
      .a_pin(pa_in), .b_pin(pb_in));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus cycle; answer taken just after the edge that samples the strobe
   task automatic acc(input logic [2:0] rg, input logic r, input logic [9:0] a,
      input logic [7:0] d);
      @(posedge core_clk);
      {rom_s, ram_s, io_s} <= rg;
      stb <= 1'b1;
      rnw <= r;
      adr <= a;
      din <= d;
      @(posedge core_clk);
      stb <= 1'b0;
      #1;
      rv = dout;
      ov = doe_n;
   endtask
   task automatic rd(input logic [2:0] rg, input logic [9:0] a, input logic [7:0] e,
      input string nm);
      acc(rg, 1'b1, a, 8'h00);
      chk(nm, e, rv);
      chk("read_enable", 8'h00, ov);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Watchdog, several times the expected run
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      final_report();
   end
   initial begin
      // Reset falls just after time zero so the async clear is never missed
      rstn = 1'b1;
      {stb, rnw, rom_s, ram_s, io_s, adr, din, ea_en, ea_v, eb_v} = '0;
      #1 rstn = 1'b0;
      eb_en = 8'h60; // Selects held active; port B direction stays input for bit 7
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(3'b001, 10'h001, 8'h00, "dir_a");
      rd(3'b001, 10'h003, 8'h00, "dir_b");
      rd(3'b001, 10'h000, 8'hff, "pins_a");
      for (k = 0; k < 64; k++)
         acc(3'b010, 1'b0, k[9:0], k[7:0] ^ 8'ha5);
      for (k = 0; k < 64; k++)
         rd(3'b010, k[9:0], k[7:0] ^ 8'ha5, "ram");
      acc(3'b100, 1'b0, 10'h155, 8'h00);
      for (k = 0; k < 1024; k += 341)
         rd(3'b100, k[9:0], k[7:0] ^ {6'h0, k[9:8]} ^ 8'h5a, "rom");
      acc(3'b000, 1'b1, 10'h000, 8'h00);
      chk("none_enable", 8'hff, ov);
      @(posedge core_clk);
      eb_v <= 8'h20;
      repeat (5) @(posedge core_clk);
      acc(3'b010, 1'b1, 10'h000, 8'h00);
      chk("desel_enable", 8'hff, ov);
      eb_v <= 8'h00;
      repeat (5) @(posedge core_clk);
      // Upper nibble driven, lower nibble from peripheral
      acc(3'b001, 1'b0, 10'h001, 8'hf0);
      acc(3'b001, 1'b0, 10'h000, 8'h3c);
      ea_en <= 8'h0f;
      ea_v <= 8'h05;
      repeat (5) @(posedge core_clk);
      chk("pa_out", 8'h3f, pa_out);
      chk("pa_oe", 8'h0f, pa_oe_n);
      rd(3'b001, 10'h000, 8'h35, "port_a");
      rd(3'b001, 10'h000, 8'h35, "port_a_again");
      // Port B low nibble driven, bit 4 and bit 7 pulled up, selects held low
      acc(3'b001, 1'b0, 10'h003, 8'h0f);
      acc(3'b001, 1'b0, 10'h002, 8'h0a);
      repeat (5) @(posedge core_clk);
      chk("pb_out", 8'hfa, pb_out);
      chk("pb_oe", 8'hf0, pb_oe_n);
      rd(3'b001, 10'h002, 8'h9a, "port_b");
      rd(3'b001, 10'h003, 8'h0f, "dir_b_rd");
      // Prescale codes, read mid-interval after three ticks
      for (k = 1; k < 4; k++) begin
         n = 1 << ((k == 3) ? 10 : 3 * k);
         acc(3'b001, 1'b0, 10'h004 | k[9:0], 8'h05);
         repeat (3 * n + n / 2 - 2) @(posedge core_clk);
         rd(3'b001, 10'h004, 8'h02, "count");
      end
      acc(3'b001, 1'b0, 10'h00c, 8'h01);
      repeat (6) @(posedge core_clk);
      chk("irq_pin", 8'h00, {7'h0, pb_out[7] | pb_oe_n[7]});
      rd(3'b001, 10'h00d, 8'h80, "flag");
      acc(3'b001, 1'b1, 10'h004, 8'h00); // Address bit 3 low
      t0 = rv;
      rd(3'b001, 10'h004, t0 - 8'h02, "elapsed");
      rd(3'b001, 10'h005, 8'h00, "flag_rd_clr");
      chk("irq_off", 8'h01, {7'h0, pb_oe_n[7]});
      acc(3'b001, 1'b0, 10'h004, 8'h00);
      repeat (4) @(posedge core_clk);
      rd(3'b001, 10'h005, 8'h80, "flag_zero");
      chk("irq_masked", 8'h01, {7'h0, pb_oe_n[7]});
      acc(3'b001, 1'b0, 10'h004, 8'h80);
      rd(3'b001, 10'h005, 8'h00, "flag_wr_clr");
      // Wrap at divide by 8; after a clearing read the count still steps per clock
      acc(3'b001, 1'b0, 10'h005, 8'h00);
      repeat (12) @(posedge core_clk);
      acc(3'b001, 1'b1, 10'h004, 8'h00);
      t0 = rv;
      rd(3'b001, 10'h004, t0 - 8'h02, "fast_after_clr");
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(3'b001, 10'h001, 8'h00, "dir_a_rst");
      chk("pa_oe_rst", 8'hff, pa_oe_n);
      final_report();
   end
endmodule // testbench
`default_nettype wire
